// ---- tb/scdsel_bench.sv ----
// Self-checking bench of the clock divider select block
`timescale 1ns/1ps
module scdsel_bench;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, sys_en, mc_en, cer_en, rc_en, pin_t, ring_t;
    logic bram = 1'b0;
    logic [1:0] rg = 2'h1;
    logic [1:0] pg = 2'h1;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int samples_checked = 0;
    int mode_m, src_m, watch, cnt, scnt, sk1, sk2;

    initial
    begin
        forever #10 clock = ~clock;
    end

    scdsel_top u_scdsel_top
    (
        .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_input_pin_tick(pin_t), .ring_osc_tick(ring_t),
        .ram_backup_return(bram), .sys_clk_en(sys_en),
        .machine_cycle_en(mc_en), .ceramic_amp_en(cer_en),
        .rc_osc_en(rc_en)
    );

    scdsel_src_model u_scdsel_src_model
    (
        .clock(clock), .rst_b(rst_b), .ring_gap(rg), .pin_gap(pg),
        .ring_tick(ring_t), .pin_tick(pin_t)
    );

    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // Request held until the edge where pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Skip the first intervals: a divide change may bend one period
    task automatic observe(input string nm);
        watch = 0;
        repeat (20) @(posedge clock);
        watch = 1;
        repeat (400) @(posedge clock);
        watch = 0;
        $display("test %s done", nm);
    endtask : observe

    // Reference: ticks per system clock and system clocks per cycle
    always @(negedge clock)
    begin
        if (!watch)
        begin
            cnt = 0;
            scnt = 0;
            sk1 = 2;
            sk2 = 2;
        end
        else
        begin
            if (sys_en === 1'b1)
            begin
                if (sk1 > 0)
                    sk1--;
                else
                    chk("ticks", cnt, 1 << ((mode_m >> 2) & 3));
                cnt = 0;
            end
            cnt += (src_m == 0) ? ring_t : pin_t;
            if (mc_en === 1'b1)
            begin
                if (sk2 > 0)
                    sk2--;
                else
                    chk("sys per mc", scnt, 3);
                scnt = 0;
            end
            scnt += (sys_en === 1'b1);
        end
    end

    initial
    begin
        #300_000;
        err_total++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(32'ha9c2));
        src_m = 0;
        mode_m = 12;
        watch = 0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        rg <= 2'(1 + $urandom() % 3);
        pg <= 2'(1 + $urandom() % 3);
        apb(1'b0, scdsel_pkg::STS_OFF, 32'h0);
        chk("status", rd, 32'h0000_0019);
        apb(1'b0, scdsel_pkg::MODE_OFF, 32'h0);
        chk("mode", rd, 32'h0000_000C);
        chk("rc", rc_en, 32'h0);
        chk("cer", cer_en, 32'h0);
        for (int dv = 0; dv < 4; dv++)
        begin
            mode_m = dv * 4 + ($urandom() % 4);
            apb(1'b1, scdsel_pkg::MODE_OFF, mode_m);
            apb(1'b0, scdsel_pkg::MODE_OFF, 32'h0);
            chk("mode", rd, mode_m);
            observe("divide");
        end
        apb(1'b1, 12'h0FC, 32'h0000_0005);
        chk("err", er, 32'h1);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped", {rd[30:0], er}, 32'h1);
        // Leave divide-by-8 first so the back-up return has work to do
        mode_m = $urandom() % 4;
        apb(1'b1, scdsel_pkg::MODE_OFF, mode_m);
        @(posedge clock);
        bram <= 1'b1;
        @(posedge clock);
        bram <= 1'b0;
        mode_m = mode_m | 12;
        apb(1'b0, scdsel_pkg::MODE_OFF, 32'h0);
        chk("backup mode", rd, mode_m);
        observe("backup");
        apb(1'b1, scdsel_pkg::CMD_OFF, 32'h0000_0001);
        src_m = 1;
        @(negedge clock);
        chk("cer", cer_en, 32'h1);
        apb(1'b0, scdsel_pkg::STS_OFF, 32'h0);
        chk("status", rd & 32'h1F, 2 | (((mode_m >> 2) & 3) << 3));
        observe("ceramic");
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        src_m = 0;
        mode_m = 12;
        apb(1'b0, scdsel_pkg::MODE_OFF, 32'h0);
        chk("mode", rd, 32'h0000_000C);
        chk("cer", cer_en, 32'h0);
        apb(1'b1, scdsel_pkg::CMD_OFF, 32'h0000_0002);
        src_m = 2;
        @(negedge clock);
        chk("rc", rc_en, 32'h1);
        apb(1'b0, scdsel_pkg::STS_OFF, 32'h0);
        chk("status", rd & 32'h1F, 32'h0000_001C);
        observe("rc");
        wrap_up();
    end
endmodule : scdsel_bench

// ---- tb/scdsel_src_model.sv ----
// Model of the ring oscillator and the oscillator pin clock sources
`timescale 1ns/1ps
module scdsel_src_model
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [1:0] ring_gap,
    input wire logic [1:0] pin_gap,
    output logic ring_tick,
    output logic pin_tick
);
    int rc;
    int pc;

    // A pin gap of zero means no clock on the pin: it stands still at 0
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rc = 0;
            pc = 0;
            ring_tick <= 1'b0;
            pin_tick <= 1'b0;
        end
        else
        begin
            ring_tick <= (rc == 0);
            rc = (rc + 1 >= ring_gap) ? 0 : rc + 1;
            pin_tick <= (pin_gap != 0) && (pc == 0);
            pc = (pc + 1 >= pin_gap) ? 0 : pc + 1;
        end
    end
endmodule : scdsel_src_model

// ---- verilog/scdsel_div_if.sv ----
// Link between the control logic and the divider chain
`timescale 1ns/1ps
interface scdsel_div_if;
    logic src_tick;
    logic [1:0] div_sel;
    logic restart;
    logic sys_en;
    logic mc_en;
    logic [1:0] mc_phase;

    modport ctrl
    (
        output src_tick,
        output div_sel,
        output restart,
        input sys_en,
        input mc_en,
        input mc_phase
    );

    modport div
    (
        input src_tick,
        input div_sel,
        input restart,
        output sys_en,
        output mc_en,
        output mc_phase
    );
endinterface : scdsel_div_if

// ---- verilog/scdsel_divider.sv ----
// Source clock divider and divide-by-three machine cycle stage
`timescale 1ns/1ps
module scdsel_divider
(
    input wire logic clock,
    input wire logic rst_b,
    scdsel_div_if.div dv
);

    typedef struct packed
    {
        logic [2:0] cnt;
        logic [1:0] mc;
        logic sys_en;
        logic mc_en;
    } scdsel_div_state_t;

    scdsel_div_state_t q;
    scdsel_div_state_t d;
    logic [2:0] limit;

    assign limit = scdsel_pkg::scdsel_div_limit(dv.div_sel);

    always_comb
    begin
        d = q;
        d.sys_en = 1'b0;
        d.mc_en = 1'b0;
        // Restart keeps a shortened ratio from running past its last count
        if (dv.restart)
        begin
            d.cnt = scdsel_pkg::CNT_RST;
        end
        else if (dv.src_tick)
        begin
            if (q.cnt >= limit)
            begin
                d.cnt = scdsel_pkg::CNT_RST;
                d.sys_en = 1'b1;
            end
            else
            begin
                d.cnt = q.cnt + 3'h1;
            end
        end
        if (q.sys_en)
        begin
            if (q.mc == scdsel_pkg::MC_LAST)
            begin
                d.mc = scdsel_pkg::MC_RST;
                d.mc_en = 1'b1;
            end
            else
            begin
                d.mc = q.mc + 2'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '{cnt: scdsel_pkg::CNT_RST, mc: scdsel_pkg::MC_RST,
                   sys_en: 1'b0, mc_en: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign dv.sys_en = q.sys_en;
    assign dv.mc_en = q.mc_en;
    assign dv.mc_phase = q.mc;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    a_div_last_tick: assert property (
        dv.src_tick && !dv.restart && q.cnt == limit |=> dv.sys_en)
        else $error("system clock pulse missing at last source tick");

    a_div_no_early: assert property (
        dv.src_tick && !dv.restart && q.cnt < limit |=> !dv.sys_en)
        else $error("system clock pulse came too early");

    a_mc_third_pulse: assert property (
        dv.sys_en && q.mc == scdsel_pkg::MC_LAST |=> dv.mc_en)
        else $error("machine cycle pulse missing after third system clock");

    a_mc_single_pulse: assert property (
        dv.mc_en |=> !dv.mc_en [*2])
        else $error("machine cycles closer than three system clocks");

endmodule : scdsel_divider

// ---- verilog/scdsel_pkg.sv ----
// Shared constants, types and helpers of the clock divider select block
package scdsel_pkg;

    // Register byte offsets on the register bus
    localparam logic [11:0] MODE_OFF = 12'h000;
    localparam logic [11:0] CMD_OFF = 12'h004;
    localparam logic [11:0] STS_OFF = 12'h008;

    // Clock mode control fields
    localparam int MODE_W = 4;
    localparam int DIV_LSB = 2;
    localparam int DIV_MSB = 3;
    localparam logic [3:0] MODE_RST = 4'hC;
    localparam logic [1:0] DIV_DEFAULT = 2'h3;

    // Source command bits
    localparam int CMD_CER_BIT = 0;
    localparam int CMD_RC_BIT = 1;

    // Status fields
    localparam int STS_SRC_LSB = 0;
    localparam int STS_DIV_LSB = 3;
    localparam int STS_PH_LSB = 5;

    // Machine cycle and source divider counters, read data reset
    localparam logic [1:0] MC_LAST = 2'h2;
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [1:0] MC_RST = 2'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [2:0]
    {
        SCDSEL_SRC_RING = 3'b001,
        SCDSEL_SRC_CER = 3'b010,
        SCDSEL_SRC_RC = 3'b100
    } scdsel_src_t;

    // Last count value of the source clock divider for a divide setting
    function automatic logic [2:0] scdsel_div_limit(input logic [1:0] sel);
        logic [2:0] lim;
        lim = 3'h7;
        case (sel)
            2'h0: lim = 3'h0;
            2'h1: lim = 3'h1;
            2'h2: lim = 3'h3;
            default: lim = 3'h7;
        endcase
        return lim;
    endfunction : scdsel_div_limit

endpackage : scdsel_pkg

// ---- verilog/scdsel_top.sv ----
// Clock source select, system clock divider and machine cycle generator
// What this block does
// - Clock mode bits 3:2 divide the source by 1, 2, 4 or 8 (00,01,10,11).
// - Reset and return from RAM back-up force the divide-by-8 mode.
// - The divide setting applies the same to every source clock.
// - The instruction clock is the system clock divided by three.
// - Each instruction clock period is one machine cycle.
// - The on-chip oscillator runs the block until software picks another.
// - The ceramic command selects the oscillator input pin clock.
// - The RC command selects the RC oscillation on the oscillator input.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module scdsel_top
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_input_pin_tick,
    input wire logic ring_osc_tick,
    input wire logic ram_backup_return,
    output logic sys_clk_en,
    output logic machine_cycle_en,
    output logic ceramic_amp_en,
    output logic rc_osc_en
);

    typedef struct packed
    {
        logic [3:0] mode;
        scdsel_pkg::scdsel_src_t src;
        logic restart;
        logic [31:0] rdata;
    } scdsel_top_state_t;

    scdsel_top_state_t q;
    scdsel_top_state_t d;
    scdsel_div_if dv ();

    logic setup;
    logic access;
    logic wr;
    logic mode_wr;
    logic cmd_wr;

    // Mapped register offsets
    function automatic logic addr_hit(input logic [11:0] a);
        return a == scdsel_pkg::MODE_OFF || a == scdsel_pkg::CMD_OFF ||
               a == scdsel_pkg::STS_OFF;
    endfunction : addr_hit

    // Read value of a register; the command register reads as zero
    function automatic logic [31:0] read_value(
        input logic [11:0] a,
        input scdsel_top_state_t s,
        input logic [1:0] ph
    );
        logic [31:0] v;
        v = scdsel_pkg::RDATA_RST;
        if (a == scdsel_pkg::MODE_OFF)
        begin
            v[scdsel_pkg::MODE_W-1:0] = s.mode;
        end
        else if (a == scdsel_pkg::STS_OFF)
        begin
            v[scdsel_pkg::STS_SRC_LSB +: 3] = s.src;
            v[scdsel_pkg::STS_DIV_LSB +: 2] =
                s.mode[scdsel_pkg::DIV_MSB:scdsel_pkg::DIV_LSB];
            v[scdsel_pkg::STS_PH_LSB +: 2] = ph;
        end
        return v;
    endfunction : read_value

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite && addr_hit(paddr);
    assign mode_wr = wr && paddr == scdsel_pkg::MODE_OFF;
    assign cmd_wr = wr && paddr == scdsel_pkg::CMD_OFF;

    always_comb
    begin
        d = q;
        // Read data is caught in the setup cycle so the answer needs no wait
        if (setup)
        begin
            d.rdata = read_value(paddr, q, dv.mc_phase);
        end
        if (ram_backup_return)
        begin
            d.mode[scdsel_pkg::DIV_MSB:scdsel_pkg::DIV_LSB] =
                scdsel_pkg::DIV_DEFAULT;
        end
        else if (mode_wr)
        begin
            d.mode = pwdata[scdsel_pkg::MODE_W-1:0];
        end
        if (cmd_wr)
        begin
            // Ceramic wins when both command bits are written together
            if (pwdata[scdsel_pkg::CMD_CER_BIT])
            begin
                d.src = scdsel_pkg::SCDSEL_SRC_CER;
            end
            else if (pwdata[scdsel_pkg::CMD_RC_BIT])
            begin
                d.src = scdsel_pkg::SCDSEL_SRC_RC;
            end
        end
        d.restart = d.mode[scdsel_pkg::DIV_MSB:scdsel_pkg::DIV_LSB] !=
                    q.mode[scdsel_pkg::DIV_MSB:scdsel_pkg::DIV_LSB];
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '{mode: scdsel_pkg::MODE_RST,
                   src: scdsel_pkg::SCDSEL_SRC_RING,
                   restart: 1'b0,
                   rdata: scdsel_pkg::RDATA_RST};
        end
        else
        begin
            q <= d;
        end
    end

    // Source mux; both pin modes share one pin, only the pad setup differs
    always_comb
    begin
        case (q.src)
            scdsel_pkg::SCDSEL_SRC_RING: dv.src_tick = ring_osc_tick;
            scdsel_pkg::SCDSEL_SRC_CER: dv.src_tick = osc_input_pin_tick;
            scdsel_pkg::SCDSEL_SRC_RC: dv.src_tick = osc_input_pin_tick;
            default: dv.src_tick = ring_osc_tick;
        endcase
    end

    // One divide setting, whatever the source
    assign dv.div_sel = q.mode[scdsel_pkg::DIV_MSB:scdsel_pkg::DIV_LSB];
    assign dv.restart = q.restart;

    scdsel_divider u_div
    (
        .clock(clock),
        .rst_b(rst_b),
        .dv(dv)
    );

    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = access && !addr_hit(paddr);
    assign sys_clk_en = dv.sys_en;
    assign machine_cycle_en = dv.mc_en;
    assign ceramic_amp_en = q.src == scdsel_pkg::SCDSEL_SRC_CER;
    assign rc_osc_en = q.src == scdsel_pkg::SCDSEL_SRC_RC;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence s_mode_wr;
        mode_wr && !ram_backup_return;
    endsequence

    sequence s_cmd_wr;
        cmd_wr && !mode_wr && !ram_backup_return;
    endsequence

    a_mode_write: assert property (
        s_mode_wr |=> dv.div_sel == $past(pwdata[3:2]))
        else $error("divide setting not taken from mode write");

    a_backup_default: assert property (
        ram_backup_return |=> dv.div_sel == scdsel_pkg::DIV_DEFAULT)
        else $error("back-up return did not force divide by eight");

    a_div_shared: assert property (
        s_cmd_wr |=> $stable(dv.div_sel))
        else $error("source change disturbed the divide setting");

    a_ring_source: assert property (
        q.src == scdsel_pkg::SCDSEL_SRC_RING |-> dv.src_tick == ring_osc_tick)
        else $error("on-chip oscillator not driving the divider");

    a_pin_source: assert property (
        q.src != scdsel_pkg::SCDSEL_SRC_RING
        |-> dv.src_tick == osc_input_pin_tick)
        else $error("pin clock not driving the divider");

    a_ceramic_cmd: assert property (
        s_cmd_wr ##0 pwdata[0] |=> ceramic_amp_en && !rc_osc_en)
        else $error("ceramic command did not select the pin clock");

    a_rc_cmd: assert property (
        s_cmd_wr ##0 (!pwdata[0] && pwdata[1])
        |=> rc_osc_en && !ceramic_amp_en)
        else $error("RC command did not select RC oscillation");

    // Read path: the answer is caught in the setup cycle, so check it there
    sequence s_setup_mode;
        setup && paddr == scdsel_pkg::MODE_OFF;
    endsequence

    sequence s_setup_cmd;
        setup && paddr == scdsel_pkg::CMD_OFF;
    endsequence

    sequence s_setup_sts;
        setup && paddr == scdsel_pkg::STS_OFF;
    endsequence

    sequence s_div_change;
        dv.div_sel != $past(dv.div_sel);
    endsequence

    a_read_mode: assert property (
        s_setup_mode |=> prdata == {28'h000_0000, $past(q.mode)})
        else $error("mode read data not taken in the setup cycle");

    a_read_cmd_zero: assert property (
        s_setup_cmd |=> prdata == scdsel_pkg::RDATA_RST)
        else $error("command register did not read as zero");

    a_read_unmapped: assert property (
        setup && !addr_hit(paddr) |=> prdata == scdsel_pkg::RDATA_RST)
        else $error("unmapped address did not read as zero");

    a_status_src: assert property (
        s_setup_sts |=> prdata[2:0] == $past(q.src))
        else $error("status source field wrong");

    a_status_div: assert property (
        s_setup_sts |=> prdata[4:3] == $past(dv.div_sel))
        else $error("status divide field wrong");

    a_status_phase: assert property (
        s_setup_sts |=> prdata[6:5] == $past(dv.mc_phase))
        else $error("status phase field wrong");

    // Divider chain as seen from the block's outputs
    a_restart_change: assert property (
        s_div_change |-> dv.restart)
        else $error("divide change did not restart the divider");

    a_restart_quiet: assert property (
        dv.restart |=> !sys_clk_en)
        else $error("system clock pulse during divider restart");

    a_sys_from_tick: assert property (
        sys_clk_en |-> $past(dv.src_tick))
        else $error("system clock pulse without a source tick");

    a_mc_after_sys: assert property (
        machine_cycle_en |-> $past(sys_clk_en))
        else $error("machine cycle pulse without a system clock");

    a_mode_hold: assert property (
        !mode_wr && !ram_backup_return |=> $stable(q.mode))
        else $error("mode changed without a write");

    a_mode_low_bits: assert property (
        s_mode_wr |=> q.mode[1:0] == $past(pwdata[1:0]))
        else $error("mode low bits not taken from write");

    a_backup_low_kept: assert property (
        ram_backup_return |=> q.mode[1:0] == $past(q.mode[1:0]))
        else $error("back-up return disturbed the mode low bits");

    a_bad_addr_ignored: assert property (
        access && !addr_hit(paddr) && !ram_backup_return
        |=> $stable(q.mode) && $stable(q.src))
        else $error("unmapped access changed the state");

    // Source selection only moves on a command, and never back
    a_src_onehot: assert property (
        $onehot(q.src))
        else $error("source select is not one-hot");

    a_amp_exclusive: assert property (
        !(ceramic_amp_en && rc_osc_en))
        else $error("ceramic and RC selected together");

    a_src_hold: assert property (
        !cmd_wr |=> $stable(q.src))
        else $error("source changed without a command");

    a_empty_cmd: assert property (
        cmd_wr && pwdata[1:0] == 2'h0 |=> $stable(q.src))
        else $error("empty command changed the source");

    a_no_ring_return: assert property (
        q.src != scdsel_pkg::SCDSEL_SRC_RING
        |=> q.src != scdsel_pkg::SCDSEL_SRC_RING)
        else $error("source fell back to the on-chip oscillator");

    a_rc_pin_source: assert property (
        rc_osc_en |-> dv.src_tick == osc_input_pin_tick)
        else $error("RC selection not driving the divider");

endmodule : scdsel_top
